/* File: logic/shifter_bit_field_defs.vh */
`ifndef SHIFTER_BIT_FIELD_DEFS_VH
`define SHIFTER_BIT_FIELD_DEFS_VH

// ==========================================================================
// register byte offsets
`define ADDR_COMMAND     8'h00
`define ADDR_SOURCE      8'h04
`define ADDR_OPERAND     8'h08
`define ADDR_DEST        8'h0c
`define ADDR_RESULT      8'h10
`define ADDR_RESULT_EXT  8'h14
`define ADDR_FLAGS       8'h18
`define ADDR_INT_STATUS  8'h1c
`define ADDR_INT_MASK    8'h20

// ==========================================================================
// operation codes, command bits [2:0]
`define OP_ROTATE        3'h0
`define OP_BIT_CLEAR     3'h1
`define OP_BIT_SET       3'h2
`define OP_BIT_TOGGLE    3'h3
`define OP_BIT_TEST      3'h4
`define OP_DEPOSIT       3'h5
`define OP_DEPOSIT_OR    3'h6

// ==========================================================================
// command field positions
`define CMD_OP_LSB       0
`define CMD_OP_MSB       2
`define CMD_USE_IMM      3
`define CMD_IMM8_LSB     8
`define CMD_IMM8_MSB     15
`define CMD_IMM_LEN_LSB  8
`define CMD_IMM_LEN_MSB  13
`define CMD_IMM_POS_LSB  14
`define CMD_IMM_POS_MSB  19

// operand register fields used by the deposit operations
`define OPND_LEN_LSB     0
`define OPND_LEN_MSB     5
`define OPND_POS_LSB     6
`define OPND_POS_MSB     11

// ==========================================================================
// flag and interrupt bit positions
`define FLAG_ZERO        0
`define FLAG_OVERFLOW    1
`define FLAG_SIGN        2
`define FLAG_WROTE       3
`define INT_DONE         0
`define INT_OVERFLOW     1

// ==========================================================================
// widths, limits and reset values
`define FIXED_WIDTH      32
`define EXT_WIDTH        8
`define BIT_LIMIT        32'sd31
`define DEPOSIT_LIMIT    7'd32
`define FULL_LENGTH      6'd32
`define RESET_WORD       32'h0000_0000
`define RESET_CMD        32'h0000_0000
`define RESET_MASK       2'h0

`endif

/* File: logic/shifter_bit_field_ops.v */
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ps
`include "shifter_bit_field_defs.vh"

// Operation
// - rotate by signed register or immediate amount
// - immediate rotate amount spans -128 to 127
// - rotate sets zero from result, clears overflow and sign
// - result fixed field, low eight bits zero
// - bit position from register or immediate
// - clear bit, out-of-range leaves source
// - set bit, out-of-range leaves source
// - toggle bit, out-of-range leaves source
// - bit ops: zero, overflow above 31, sign cleared
// - bit test writes nothing, zero from bit
// - test above 31 sets zero and overflow
// - deposit right-aligned field at length, position
// - plain deposit zeroes bits outside field
// - length and position are six-bit unsigned
// - deposit flags: overflow when sum exceeds 32
// - merging deposit ORs with destination contents
module shifter_bit_field_ops #(
    parameter WORD_WIDTH = 40,
    parameter ADDR_WIDTH = 8
) (
    input wire mclk,                        // core clock, 200 MHz
    input wire rst_n,                       // synchronous reset
    input wire psel,                        // apb select
    input wire penable,                     // apb access phase
    input wire pwrite,                      // apb direction
    input wire [ADDR_WIDTH-1:0] paddr,      // apb byte address
    input wire [31:0] pwdata,               // apb write data
    output reg [31:0] prdata,               // apb read data
    output reg pready,                      // apb ready
    output reg pslverr,                     // apb error, unmapped
    output reg irq,                         // level interrupt
    output reg [WORD_WIDTH-1:0] resultWord, // last destination word
    output reg resultWrite,                 // destination write pulse
    output reg shifterZeroFlag,             // zero flag
    output reg shifterOverflowFlag,         // overflow flag
    output reg shifterSignFlag              // sign flag
);

    // ======================================================================
    // helpers

    function [31:0] signExtend8;
        input [7:0] value;
        begin
            signExtend8 = {{24{value[7]}}, value};
        end
    endfunction

    function isMapped;
        input [ADDR_WIDTH-1:0] addr;
        begin
            case (addr)
                `ADDR_COMMAND, `ADDR_SOURCE, `ADDR_OPERAND, `ADDR_DEST,
                `ADDR_RESULT, `ADDR_RESULT_EXT, `ADDR_FLAGS,
                `ADDR_INT_STATUS, `ADDR_INT_MASK:
                    isMapped = 1'b1;
                default:
                    isMapped = 1'b0;
            endcase
        end
    endfunction

    // zero flag test shared by every operation that produces a word
    function isZero;
        input [31:0] value;
        begin
            isZero = ~(|value);
        end
    endfunction

    // ======================================================================
    // state

    reg [31:0] commandQ;
    reg [31:0] sourceQ;
    reg [31:0] operandQ;
    reg [31:0] destQ;
    reg [31:0] resultQ;
    reg wroteQ;
    reg startQ;
    reg [1:0] intStatusQ;
    reg [1:0] intMaskQ;

    // ======================================================================
    // bus decode

    wire accessPhase = psel & penable;
    // one wait state: read data settles before pready is raised
    wire busCommit = accessPhase & pready;
    wire busWrite = busCommit & pwrite & isMapped(paddr);

    // per-register write strobes, shared by every user of a register
    wire writeCommand = busWrite & (paddr == `ADDR_COMMAND);
    wire writeSource = busWrite & (paddr == `ADDR_SOURCE);
    wire writeOperand = busWrite & (paddr == `ADDR_OPERAND);
    wire writeDest = busWrite & (paddr == `ADDR_DEST);
    wire writeIntStatus = busWrite & (paddr == `ADDR_INT_STATUS);
    wire writeIntMask = busWrite & (paddr == `ADDR_INT_MASK);

    // ======================================================================
    // operand selection

    wire [2:0] opCode = commandQ[`CMD_OP_MSB:`CMD_OP_LSB];
    wire useImm = commandQ[`CMD_USE_IMM];
    wire [7:0] imm8 = commandQ[`CMD_IMM8_MSB:`CMD_IMM8_LSB];
    wire [31:0] amount = useImm ? signExtend8(imm8) : operandQ;

    wire [5:0] fieldLength = useImm ?
        commandQ[`CMD_IMM_LEN_MSB:`CMD_IMM_LEN_LSB] :
        operandQ[`OPND_LEN_MSB:`OPND_LEN_LSB];
    wire [5:0] fieldPosition = useImm ?
        commandQ[`CMD_IMM_POS_MSB:`CMD_IMM_POS_LSB] :
        operandQ[`OPND_POS_MSB:`OPND_POS_LSB];

    // ======================================================================
    // rotate

    // low five bits of a two's-complement amount give the left rotation
    wire [4:0] rotateLeft = amount[4:0];
    wire [63:0] rotateWide = {sourceQ, sourceQ} << rotateLeft;
    wire [31:0] rotated = rotateWide[63:32];

    // ======================================================================
    // single bit operations

    wire posNegative = amount[31];
    // a negative position is out of range but never an overflow
    wire posTooHigh = ~amount[31] & (|amount[30:5]);
    wire posValid = ~posNegative & ~posTooHigh;
    wire [31:0] bitMask;
    wire [31:0] lengthMask;

    // one mask bit per field bit, shared by bit and deposit operations
    genvar b;
    generate
        for (b = 0; b < `FIXED_WIDTH; b = b + 1)
        begin : maskBit
            localparam [5:0] INDEX = b;
            // an out-of-range position selects no bit at all
            assign bitMask[b] = posValid & (amount[5:0] == INDEX);
            // a length of 32 or more keeps the whole source field
            assign lengthMask[b] = fieldLength > INDEX;
        end
    endgenerate

    wire [31:0] clearedWord = sourceQ & ~bitMask;
    wire [31:0] setWord = sourceQ | bitMask;
    wire [31:0] toggledWord = sourceQ ^ bitMask;
    // a negative position tests no bit, so zero reads as set
    wire testedZero = ~posValid | ~(|(sourceQ & bitMask));

    // ======================================================================
    // field deposit

    wire [95:0] placedWide = {64'h0, sourceQ & lengthMask} << fieldPosition;
    // bits pushed past the top of the word are dropped
    wire [31:0] deposited = placedWide[31:0];
    // seven bits so a 63 plus 63 sum cannot wrap below the limit
    wire [6:0] fieldEnd = {1'b0, fieldLength} + {1'b0, fieldPosition};
    wire depositOverflow = fieldEnd > `DEPOSIT_LIMIT;

    // ======================================================================
    // result and flags

    reg [31:0] resultD;
    reg zeroD;
    reg overflowD;
    reg writesD;

    always @*
    begin
        resultD = resultQ;
        zeroD = 1'b0;
        overflowD = 1'b0;
        writesD = 1'b1;
        case (opCode)
            `OP_ROTATE:
            begin
                resultD = rotated;
                zeroD = isZero(rotated);
            end
            `OP_BIT_CLEAR:
            begin
                resultD = clearedWord;
                zeroD = isZero(clearedWord);
                overflowD = posTooHigh;
            end
            `OP_BIT_SET:
            begin
                resultD = setWord;
                zeroD = isZero(setWord);
                overflowD = posTooHigh;
            end
            `OP_BIT_TOGGLE:
            begin
                resultD = toggledWord;
                zeroD = isZero(toggledWord);
                overflowD = posTooHigh;
            end
            `OP_BIT_TEST:
            begin
                writesD = 1'b0;
                zeroD = testedZero;
                overflowD = posTooHigh;
            end
            `OP_DEPOSIT:
            begin
                resultD = deposited;
                zeroD = isZero(deposited);
                overflowD = depositOverflow;
            end
            `OP_DEPOSIT_OR:
            begin
                resultD = deposited | destQ;
                zeroD = isZero(deposited | destQ);
                overflowD = depositOverflow;
            end
            default:
            begin
                // undefined code: nothing written, flags cleared
                writesD = 1'b0;
            end
        endcase
    end

    // ======================================================================
    // register file and operation sequencing

    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            commandQ <= `RESET_CMD;
            sourceQ <= `RESET_WORD;
            operandQ <= `RESET_WORD;
            destQ <= `RESET_WORD;
            resultQ <= `RESET_WORD;
            wroteQ <= 1'b0;
            startQ <= 1'b0;
            resultWord <= {WORD_WIDTH{1'b0}};
            resultWrite <= 1'b0;
            shifterZeroFlag <= 1'b0;
            shifterOverflowFlag <= 1'b0;
            shifterSignFlag <= 1'b0;
        end
        else
        begin
            // writing the command register launches one operation;
            // operands are read in the next cycle, while startQ is high
            startQ <= writeCommand;
            resultWrite <= 1'b0;
            if (writeCommand)
                commandQ <= pwdata;
            if (writeSource)
                sourceQ <= pwdata;
            if (writeOperand)
                operandQ <= pwdata;
            if (startQ)
            begin
                shifterZeroFlag <= zeroD;
                shifterOverflowFlag <= overflowD;
                shifterSignFlag <= 1'b0;
                wroteQ <= writesD;
                if (writesD)
                begin
                    resultQ <= resultD;
                    destQ <= resultD;
                    resultWord <= {resultD, {`EXT_WIDTH{1'b0}}};
                    resultWrite <= 1'b1;
                end
            end
            // an operation's own write takes priority over a bus write
            else if (writeDest)
                destQ <= pwdata;
        end
    end

    // ======================================================================
    // interrupt status, write one to clear; a new event wins over a clear

    wire [1:0] intEvents = {startQ & overflowD, startQ};
    wire [1:0] intClear = writeIntStatus ? pwdata[1:0] : 2'h0;
    // irq is formed from next state so it never lags the status bits
    wire [1:0] maskNext = writeIntMask ? pwdata[1:0] : intMaskQ;
    wire [1:0] statusNext;

    // set wins, so an event in the clearing cycle is never lost
    genvar s;
    generate
        for (s = 0; s < 2; s = s + 1)
        begin : statusBit
            assign statusNext[s] = (intStatusQ[s] & ~intClear[s]) |
                                   intEvents[s];
        end
    endgenerate

    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            intStatusQ <= 2'h0;
            intMaskQ <= `RESET_MASK;
            irq <= 1'b0;
        end
        else
        begin
            intStatusQ <= statusNext;
            intMaskQ <= maskNext;
            irq <= |(statusNext & maskNext);
        end
    end

    // ======================================================================
    // apb read path and ready

    reg [31:0] readMux;

    always @*
    begin
        readMux = 32'h0000_0000;
        case (paddr)
            `ADDR_COMMAND:
                readMux = commandQ;
            `ADDR_SOURCE:
                readMux = sourceQ;
            `ADDR_OPERAND:
                readMux = operandQ;
            `ADDR_DEST:
                readMux = destQ;
            `ADDR_RESULT:
                readMux = resultQ;
            `ADDR_RESULT_EXT:
                readMux = 32'h0000_0000;
            `ADDR_FLAGS:
                readMux = {28'h0, wroteQ, shifterSignFlag,
                           shifterOverflowFlag, shifterZeroFlag};
            `ADDR_INT_STATUS:
                readMux = {30'h0, intStatusQ};
            `ADDR_INT_MASK:
                readMux = {30'h0, intMaskQ};
            default:
                readMux = 32'h0000_0000;
        endcase
    end

    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (accessPhase && !pready)
        begin
            pready <= 1'b1;
            prdata <= readMux;
            pslverr <= ~isMapped(paddr);
        end
        else
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule // shifter_bit_field_ops

/* File: test/shifter_checker_props.sv */
`timescale 1ns/1ps
module shifter_checker (
    input wire mclk, // clock
    input wire rst_n, // reset
    input wire psel, // select
    input wire penable, // access
    input wire pwrite, // direction
    input wire [7:0] paddr, // address
    input wire [31:0] pwdata, // write data
    input wire [31:0] prdata, // read data
    input wire pready, // ready
    input wire pslverr, // error
    input wire irq, // interrupt
    input wire [39:0] resultWord, // result
    input wire resultWrite, // write pulse
    input wire shifterZeroFlag, // zero
    input wire shifterOverflowFlag, // overflow
    input wire shifterSignFlag // sign
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ==================================================================
    // command acceptance
    sequence cmdTaken;
        psel && penable && pready && pwrite && paddr == 8'h00;
    endsequence
    sequence writeOp;
        cmdTaken ##0 (pwdata[2:0] != 3'h4 && pwdata[2:0] != 3'h7);
    endsequence
    ext_zero_a:
        assert property (resultWord[7:0] == 8'h00)
        else $error("extension field not zero");
    sign_clear_a:
        assert property (!shifterSignFlag) else $error("sign flag set");
    zero_match_a:
        assert property (resultWrite |-> shifterZeroFlag ==
            (resultWord[39:8] == 32'h0)) else $error("zero flag wrong");
    op_writes_a:
        assert property (writeOp |-> ##[2:3] resultWrite)
        else $error("no destination write");
    test_quiet_a:
        assert property (cmdTaken ##0 pwdata[2:0] == 3'h4 |=>
            !resultWrite [*3]) else $error("bit test wrote");
    rotate_flags_a:
        assert property (cmdTaken ##0 pwdata[2:0] == 3'h0 |-> ##3
            !shifterOverflowFlag) else $error("rotate overflow set");
    write_pulse_a:
        assert property (resultWrite |=> !resultWrite)
        else $error("write pulse too long");
    ready_wait_a:
        assert property (psel && penable && !pready |=> pready)
        else $error("ready late");
    err_data_a:
        assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error response malformed");
endmodule // shifter_checker

bind shifter_bit_field_ops shifter_checker shifter_checker_i (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq),
    .resultWord(resultWord), .resultWrite(resultWrite),
    .shifterZeroFlag(shifterZeroFlag),
    .shifterOverflowFlag(shifterOverflowFlag),
    .shifterSignFlag(shifterSignFlag));

/* File: test/apb_host_model.sv */
`timescale 1ns/1ps
module apb_host_model (
    input wire mclk, // clock
    output logic psel, // select
    output logic penable, // access
    output logic pwrite, // direction
    output logic [7:0] paddr, // address
    output logic [31:0] pwdata, // write data
    input wire [31:0] prdata, // read data
    input wire pready, // ready
    input wire pslverr // error
);
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // ==================================================================
    // one transfer; idle cycle after it so calls never collide
    task automatic xfer(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e,
        output logic hung);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        r = prdata;
        e = pslverr;
        hung = (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d; // stale data must not look valid
        @(posedge mclk);
    endtask
endmodule // apb_host_model

/* File: test/test_shifter_bit_field_ops.sv */
`timescale 1ns/1ps
`include "shifter_bit_field_defs.vh"
module test_shifter_bit_field_ops;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    wire psel, penable, pwrite, pready, pslverr, irq, resultWrite;
    wire zeroFlag, ovfFlag, signFlag;
    wire [7:0] paddr;
    wire [31:0] pwdata, prdata;
    wire [39:0] resultWord;
    int nMismatch = 0;
    int numChecks = 0;
    logic [31:0] rdv;
    logic errv;
    always #2.5 mclk = ~mclk;
    apb_host_model host_i (.mclk(mclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    shifter_bit_field_ops shifter_bit_field_ops_i (.mclk(mclk),
        .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .resultWord(resultWord),
        .resultWrite(resultWrite), .shifterZeroFlag(zeroFlag),
        .shifterOverflowFlag(ovfFlag), .shifterSignFlag(signFlag));
    // ==================================================================
    // access and compare tasks
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", numChecks, nMismatch);
        if (nMismatch == 0 && numChecks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp, input string what);
        numChecks++;
        if (got !== exp)
        begin
            nMismatch++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        logic h;
        host_i.xfer(w, a, d, rdv, errv, h);
        if (h)
        begin
            nMismatch++;
            $display("[ERR] %0t bus hung", $time);
            report_and_stop();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
        input string what);
        bus(1'b0, a, 32'h0);
        chk(rdv, exp, what);
    endtask
    task automatic op(input logic [31:0] src, opnd, cmd, exp, dst,
        input logic [3:0] fl);
        bus(1'b1, `ADDR_SOURCE, src);
        bus(1'b1, `ADDR_OPERAND, opnd);
        bus(1'b1, `ADDR_DEST, dst);
        bus(1'b1, `ADDR_COMMAND, cmd);
        repeat (3) @(posedge mclk);
        rd(`ADDR_FLAGS, {28'h0, fl}, "flags");
        chk({29'h0, signFlag, ovfFlag, zeroFlag}, {29'h0, fl[2:0]},
            "flag pins");
        if (fl[3])
        begin
            rd(`ADDR_RESULT, exp, "result");
            chk(resultWord[39:8], exp, "word");
            chk({24'h0, resultWord[7:0]}, 32'h0, "extension");
        end
    endtask
    // ==================================================================
    // main sequence
    initial
    begin
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rd(`ADDR_FLAGS, 32'h0, "flags reset");
        rd(`ADDR_INT_MASK, 32'h0, "mask reset");
        $display("reset test done");
        op(32'h80000001, 32'h0, 32'h108, 32'h3, 32'h0, 4'h8);
        op(32'h80000001, 32'h0, 32'hff08, 32'hc0000000, 32'h0, 4'h8);
        op(32'h80000001, 32'h0, 32'h8008, 32'h80000001, 32'h0, 4'h8);
        op(32'h80000001, 32'h40, 32'h0, 32'h80000001, 32'h0, 4'h8);
        op(32'h0, 32'h0, 32'h108, 32'h0, 32'h0, 4'h9);
        op(32'h80000001, 32'h0, 32'h9, 32'h80000000, 32'h0, 4'h8);
        op(32'h80000001, 32'h20, 32'h1, 32'h80000001, 32'h0, 4'ha);
        op(32'h80000001, 32'hffffffff, 32'h1, 32'h80000001, 32'h0, 4'h8);
        op(32'h80000001, 32'h0, 32'h40a, 32'h80000011, 32'h0, 4'h8);
        op(32'h80000001, 32'h28, 32'h2, 32'h80000001, 32'h0, 4'ha);
        op(32'h80000000, 32'h0, 32'h1f0b, 32'h0, 32'h0, 4'h9);
        op(32'h80000001, 32'hfffffffb, 32'h3, 32'h80000001, 32'h0, 4'h8);
        op(32'h80000001, 32'h0, 32'hc, 32'h0, 32'h0, 4'h0);
        op(32'h80000001, 32'h0, 32'h10c, 32'h0, 32'h0, 4'h1);
        op(32'h80000001, 32'h20, 32'h4, 32'h0, 32'h0, 4'h3);
        op(32'hffffffff, 32'h34e, 32'h5, 32'h07ffe000, 32'h0, 4'h8);
        op(32'hffffffff, 32'h0, 32'h7080d, 32'hf0000000, 32'h0, 4'ha);
        op(32'hffffffff, 32'h0, 32'h5, 32'h0, 32'h0, 4'h9);
        op(32'hffffffff, 32'h60, 32'h5, 32'hfffffffe, 32'h0, 4'ha);
        op(32'hffffffff, 32'h4, 32'h6, 32'hff, 32'hf0, 4'h8);
        op(32'h80000001, 32'h0, 32'h7, 32'h0, 32'h0, 4'h0);
        $display("operation test done");
        chk({31'h0, irq}, 32'h0, "irq masked");
        bus(1'b1, `ADDR_INT_MASK, 32'h1);
        repeat (2) @(posedge mclk);
        chk({31'h0, irq}, 32'h1, "irq raised");
        rd(`ADDR_INT_STATUS, 32'h3, "status");
        bus(1'b1, `ADDR_INT_STATUS, 32'h3);
        repeat (2) @(posedge mclk);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        rd(`ADDR_INT_STATUS, 32'h0, "status cleared");
        $display("interrupt test done");
        bus(1'b1, 8'h40, 32'h1);
        chk({31'h0, errv}, 32'h1, "unmapped write");
        rd(8'h40, 32'h0, "unmapped read");
        chk({31'h0, errv}, 32'h1, "unmapped read error");
        bus(1'b1, `ADDR_RESULT, 32'h5);
        rd(`ADDR_RESULT, 32'hff, "result read only");
        $display("error test done");
        report_and_stop();
    end
endmodule // test_shifter_bit_field_ops
